// ===== sdbt_defines.vh
// Constants for the split dual byte timer register block.
// Assumes a single 250 MHz clock and an APB register bus with 32-bit data.
//
// Overview of operation
// - While stopped, each force bit sets or clears its waveform output directly.
// - Byte mode 00 is the ordinary counter; code 11 is reserved for software.
// - Byte mode 01 forces the upper counter byte to zero every count clock.
// - Byte mode 10 splits into independent low and high eight-bit counters.
// - Bits 3:2 give the high underflow request level, raised while its flag is set.
// - Bits 1:0 give the low underflow request level, raised while its flag is set.
// - Four two-bit fields give compare A to D request levels while flags set.
// - Command field reads zero; 00 none, 01 reserved, 10 restarts targeted halves.
// - Command 11 hard resets targeted halves, ignored unless the counter is stopped.
// - Target 01 low, 10 high, 11 both, 00 none; written with the command.
// - Low compare flag sets when the low count equals that channel's compare value.
// - High underflow flag sets, in split mode only, when the high counter reaches bottom.
// - Low underflow flag sets when the low counter reaches bottom.
// - Flags clear on vector acknowledge or on writing one; zero leaves them.
// - A count register write beats counting, clearing and reloading in that cycle.
// - Low and high period registers hold eight-bit periods at indices 0x27 and 0x26.
// - Four compare registers per half are compared continuously and drive waveforms.
// - In split mode each half counts down per count clock, reloading from period after bottom.
// - Restart clears counter and compare outputs of targeted halves.
// - Low match sets its flag on a count clock with an event; high has none.
// - Clock select 0000 stops; 0001 to 0111 prescaled; 1nnn event channel n.
`ifndef SDBT_DEFINES_VH
`define SDBT_DEFINES_VH

// ==================================================================
// Register indices, byte address is four times the index
`define SDBT_IDX_CLKSRC   6'h00
`define SDBT_IDX_FORCE    6'h02
`define SDBT_IDX_UPPER_ZEROED_SETTING 6'h04
`define SDBT_IDX_UNFLVL   6'h06
`define SDBT_IDX_CMPLVL   6'h07
`define SDBT_IDX_CMD      6'h08
`define SDBT_IDX_FLAGS    6'h0C
`define SDBT_IDX_LOW_COUNTER     6'h20
`define SDBT_IDX_HIGH_COUNTER     6'h21
`define SDBT_IDX_HIGH_PERIOD     6'h26
`define SDBT_IDX_LOW_PERIOD     6'h27
`define SDBT_IDX_CMP_BASE 6'h28
`define SDBT_IDX_CMP_LAST 6'h2F

// ==================================================================
// Field codes and reset values
`define SDBT_MODE_NORMAL  2'h0
`define SDBT_MODE_UPPER0  2'h1
`define SDBT_MODE_SPLIT   2'h2
`define SDBT_CMD_RESTART  2'h2
`define SDBT_CMD_HARDRST  2'h3
`define SDBT_CLK_OFF      4'h0
`define SDBT_ZERO8        8'h00
`define SDBT_ZERO32       32'h00000000
`define SDBT_FLAG_MASK    8'hF3

`endif

// ===== sdbt_prescale.v
// Count clock source: a prescaler divider and event channel selection.
// Assumes event inputs are one-cycle pulses synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
`include "sdbt_defines.vh"

module sdbt_prescale
(
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [3:0] sel_i,
  input  wire [7:0] event_i,
  output reg        tick_o
);

  reg  [9:0] div_q;
  reg        tick_d;

  // ==================================================================
  // Divider
  always @(posedge clk_i)
  begin
    if (rst_i)
      div_q <= 10'h000;
    else
      div_q <= div_q + 10'h001;
  end

  // ==================================================================
  // Selection, one enable pulse per count clock
  always @*
  begin
    tick_d = 1'b0;
    if (sel_i[3])
      tick_d = event_i[sel_i[2:0]];
    else
      case (sel_i[2:0])
        3'h1:    tick_d = 1'b1;
        3'h2:    tick_d = &div_q[0:0];
        3'h3:    tick_d = &div_q[1:0];
        3'h4:    tick_d = &div_q[2:0];
        3'h5:    tick_d = &div_q[5:0];
        3'h6:    tick_d = &div_q[7:0];
        3'h7:    tick_d = &div_q[9:0];
        default: tick_d = 1'b0;
      endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      tick_o <= 1'b0;
    else
      tick_o <= tick_d;
  end

endmodule // sdbt_prescale

`default_nettype wire

// ===== sdbt_half.v
// One eight-bit counter half with four comparators and waveform outputs.
// Assumes the parent decides when to decrement, reload, clear or force.
`timescale 1ns/1ps
`default_nettype none
`include "sdbt_defines.vh"

module sdbt_half
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        tick_i,
  input  wire        dec_i,
  input  wire        reload_i,
  input  wire        bottom_i,
  input  wire [7:0]  period_i,
  input  wire        clr_i,
  input  wire        wg_clr_i,
  input  wire        force_en_i,
  input  wire [3:0]  force_i,
  input  wire [31:0] cmp_i,
  output reg  [7:0]  cnt_o,
  output wire [3:0]  match_o,
  output reg  [3:0]  wg_o
);

  // ==================================================================
  // Counter; a bus write wins over every other action.
  always @(posedge clk_i)
  begin
    if (rst_i)
      cnt_o <= `SDBT_ZERO8;
    else if (wr_i)
      cnt_o <= wr_data_i;
    else if (clr_i)
      cnt_o <= `SDBT_ZERO8;
    else if (reload_i)
      cnt_o <= period_i;
    else if (dec_i)
      cnt_o <= cnt_o - 8'h01;
  end

  // ==================================================================
  // Comparators and single-slope waveforms: set on match, clear at bottom.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
      assign match_o[g] = (cnt_o == cmp_i[8*g+7:8*g]);
      always @(posedge clk_i)
      begin
        if (rst_i)
          wg_o[g] <= 1'b0;
        else if (force_en_i)
          wg_o[g] <= force_i[g];
        else if (wg_clr_i)
          wg_o[g] <= 1'b0;
        else if (tick_i && match_o[g])
          wg_o[g] <= 1'b1;
        else if (tick_i && bottom_i)
          wg_o[g] <= 1'b0;
      end
    end
  endgenerate

endmodule // sdbt_half

`default_nettype wire

// ===== sdbt_top.v
// Split dual byte timer: APB registers, mode control, flags and requests.
// Assumes an APB master on the same clock and an external interrupt controller
// that pulses one acknowledge per source when the vector is executed.
`timescale 1ns/1ps
`default_nettype none
`include "sdbt_defines.vh"

module sdbt_top
(
  input  wire        CLK_I,
  input  wire        RESET_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire [7:0]  EVENT_CH_I,
  input  wire [5:0]  IRQ_ACK_I,
  output reg  [11:0] IRQ_LEVEL_O,
  output reg  [5:0]  EVENT_O,
  output wire [7:0]  WAVEFORM_O
);

  // ==================================================================
  // Registers
  reg  [3:0]  count_clock_source_q;
  reg  [7:0]  wg_output_force_q;
  reg  [1:0]  half_split_select_q;
  reg  [3:0]  underflow_irq_level_q;
  reg  [7:0]  compare_irq_level_q;
  reg  [1:0]  command_target_q;
  reg  [7:0]  irq_flag_bits_q;
  reg  [7:0]  irq_flag_bits_d;
  reg  [7:0]  low_period_q;
  reg  [7:0]  high_period_q;
  reg  [31:0] low_compare_q;
  reg  [31:0] high_compare_q;
  reg  [31:0] rdata_d;
  reg         err_d;
  reg  [11:0] level_d;

  wire [5:0]  idx = PADDR_I[7:2];
  wire        setup = PSEL_I && !PENABLE_I;
  wire        wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  wire [7:0]  wd = PWDATA_I[7:0];
  wire        in_cmp = (idx >= `SDBT_IDX_CMP_BASE) && (idx <= `SDBT_IDX_CMP_LAST);
  wire [1:0]  cmp_ch = idx[2:1];
  wire        cmp_hi = idx[0];

  wire        tick;
  wire [7:0]  low_counter;
  wire [7:0]  high_counter;
  wire [3:0]  low_match;

  // ==================================================================
  // Mode and command decode
  wire stopped = (count_clock_source_q == `SDBT_CLK_OFF);
  wire split = (half_split_select_q == `SDBT_MODE_SPLIT);
  // Reserved code 11 behaves as normal mode so a stray write stays harmless.
  wire upper0 = (half_split_select_q == `SDBT_MODE_UPPER0);
  wire cmd_wr = wr && (idx == `SDBT_IDX_CMD);
  wire restart_cmd = cmd_wr && (wd[3:2] == `SDBT_CMD_RESTART);
  wire hardrst_cmd = cmd_wr && (wd[3:2] == `SDBT_CMD_HARDRST) && stopped;
  wire tgt_low = wd[0];
  wire tgt_high = wd[1];
  wire low_restart = restart_cmd && tgt_low;
  wire high_restart = restart_cmd && tgt_high;
  wire low_hardrst = hardrst_cmd && tgt_low;
  wire high_hardrst = hardrst_cmd && tgt_high;

  // ==================================================================
  // Counting; in normal mode the low half borrows from the high half.
  wire low_zero = (low_counter == `SDBT_ZERO8);
  wire high_zero = (high_counter == `SDBT_ZERO8);
  wire low_bottom = split ? low_zero : (low_zero && high_zero);
  wire high_bottom = split ? high_zero : low_bottom;
  wire low_dec = tick && !low_bottom;
  wire low_reload = tick && low_bottom;
  wire high_dec = tick && !upper0 && (split ? !high_zero : (low_zero && !high_zero));
  wire high_reload = tick && !upper0 && high_bottom;
  wire high_clr = (tick && upper0) || high_restart || high_hardrst;

  wire lunf_set = tick && low_bottom;
  wire hunf_set = tick && split && high_zero;
  wire [3:0] cmp_set = {4{tick}} & low_match;

  sdbt_prescale u_prescale
  (
    .clk_i   (CLK_I),
    .rst_i   (RESET_I),
    .sel_i   (count_clock_source_q),
    .event_i (EVENT_CH_I),
    .tick_o  (tick)
  );

  sdbt_half u_low
  (
    .clk_i      (CLK_I),
    .rst_i      (RESET_I),
    .wr_i       (wr && (idx == `SDBT_IDX_LOW_COUNTER)),
    .wr_data_i  (wd),
    .tick_i     (tick),
    .dec_i      (low_dec),
    .reload_i   (low_reload),
    .bottom_i   (low_bottom),
    .period_i   (low_period_q),
    .clr_i      (low_restart || low_hardrst),
    .wg_clr_i   (low_restart || low_hardrst),
    .force_en_i (stopped),
    .force_i    (wg_output_force_q[3:0]),
    .cmp_i      (low_compare_q),
    .cnt_o      (low_counter),
    .match_o    (low_match),
    .wg_o       (WAVEFORM_O[3:0])
  );

  sdbt_half u_high
  (
    .clk_i      (CLK_I),
    .rst_i      (RESET_I),
    .wr_i       (wr && (idx == `SDBT_IDX_HIGH_COUNTER)),
    .wr_data_i  (wd),
    .tick_i     (tick),
    .dec_i      (high_dec),
    .reload_i   (high_reload),
    .bottom_i   (high_bottom),
    .period_i   (high_period_q),
    .clr_i      (high_clr),
    .wg_clr_i   (high_restart || high_hardrst),
    .force_en_i (stopped),
    .force_i    (wg_output_force_q[7:4]),
    .cmp_i      (high_compare_q),
    .cnt_o      (high_counter),
    .match_o    (),
    .wg_o       (WAVEFORM_O[7:4])
  );

  // ==================================================================
  // Control registers
  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      count_clock_source_q  <= `SDBT_CLK_OFF;
      wg_output_force_q     <= `SDBT_ZERO8;
      half_split_select_q   <= `SDBT_MODE_NORMAL;
      underflow_irq_level_q <= 4'h0;
      compare_irq_level_q   <= `SDBT_ZERO8;
      command_target_q      <= 2'h0;
      low_period_q          <= `SDBT_ZERO8;
      high_period_q         <= `SDBT_ZERO8;
      low_compare_q         <= `SDBT_ZERO32;
      high_compare_q        <= `SDBT_ZERO32;
    end
    else
    begin
      if (wr && (idx == `SDBT_IDX_CLKSRC))
        count_clock_source_q <= wd[3:0];
      if (wr && (idx == `SDBT_IDX_FORCE))
        wg_output_force_q <= wd;
      if (wr && (idx == `SDBT_IDX_UPPER_ZEROED_SETTING))
        half_split_select_q <= wd[1:0];
      if (wr && (idx == `SDBT_IDX_UNFLVL))
        underflow_irq_level_q <= wd[3:0];
      if (wr && (idx == `SDBT_IDX_CMPLVL))
        compare_irq_level_q <= wd;
      if (cmd_wr)
        command_target_q <= wd[1:0];
      if (wr && (idx == `SDBT_IDX_LOW_PERIOD))
        low_period_q <= wd;
      if (wr && (idx == `SDBT_IDX_HIGH_PERIOD))
        high_period_q <= wd;
      if (wr && in_cmp && !cmp_hi)
        low_compare_q[8*cmp_ch +: 8] <= wd;
      if (wr && in_cmp && cmp_hi)
        high_compare_q[8*cmp_ch +: 8] <= wd;
      // Hard reset returns the targeted half's own registers to initial values.
      if (low_hardrst)
      begin
        low_period_q <= `SDBT_ZERO8;
        low_compare_q <= `SDBT_ZERO32;
        wg_output_force_q[3:0] <= 4'h0;
      end
      if (high_hardrst)
      begin
        high_period_q <= `SDBT_ZERO8;
        high_compare_q <= `SDBT_ZERO32;
        wg_output_force_q[7:4] <= 4'h0;
      end
    end
  end

  // ==================================================================
  // Flags: hardware set wins over a clear in the same cycle.
  always @*
  begin
    irq_flag_bits_d = irq_flag_bits_q;
    if (wr && (idx == `SDBT_IDX_FLAGS))
      irq_flag_bits_d = irq_flag_bits_d & ~(wd & `SDBT_FLAG_MASK);
    irq_flag_bits_d[0] = irq_flag_bits_d[0] & ~IRQ_ACK_I[0];
    irq_flag_bits_d[1] = irq_flag_bits_d[1] & ~IRQ_ACK_I[1];
    irq_flag_bits_d[7:4] = irq_flag_bits_d[7:4] & ~IRQ_ACK_I[5:2];
    if (low_hardrst)
      irq_flag_bits_d = irq_flag_bits_d & 8'h0E;
    if (high_hardrst)
      irq_flag_bits_d = irq_flag_bits_d & 8'hFD;
    irq_flag_bits_d[0] = irq_flag_bits_d[0] | lunf_set;
    irq_flag_bits_d[1] = irq_flag_bits_d[1] | hunf_set;
    irq_flag_bits_d[7:4] = irq_flag_bits_d[7:4] | cmp_set;
  end

  // ==================================================================
  // Requests carry their level; a zero level masks the source.
  always @*
  begin
    level_d = 12'h000;
    if (irq_flag_bits_q[0])
      level_d[1:0] = underflow_irq_level_q[1:0];
    if (irq_flag_bits_q[1])
      level_d[3:2] = underflow_irq_level_q[3:2];
    if (irq_flag_bits_q[4])
      level_d[5:4] = compare_irq_level_q[1:0];
    if (irq_flag_bits_q[5])
      level_d[7:6] = compare_irq_level_q[3:2];
    if (irq_flag_bits_q[6])
      level_d[9:8] = compare_irq_level_q[5:4];
    if (irq_flag_bits_q[7])
      level_d[11:10] = compare_irq_level_q[7:6];
  end

  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      irq_flag_bits_q <= `SDBT_ZERO8;
      IRQ_LEVEL_O     <= 12'h000;
      EVENT_O         <= 6'h00;
    end
    else
    begin
      irq_flag_bits_q <= irq_flag_bits_d;
      IRQ_LEVEL_O     <= level_d;
      EVENT_O         <= {cmp_set, hunf_set, lunf_set};
    end
  end

  // ==================================================================
  // APB read decode, registered in the setup phase for zero wait states.
  always @*
  begin
    rdata_d = `SDBT_ZERO32;
    err_d = 1'b0;
    if (idx == `SDBT_IDX_CLKSRC)
      rdata_d[3:0] = count_clock_source_q;
    else if (idx == `SDBT_IDX_FORCE)
      rdata_d[7:0] = wg_output_force_q;
    else if (idx == `SDBT_IDX_UPPER_ZEROED_SETTING)
      rdata_d[1:0] = half_split_select_q;
    else if (idx == `SDBT_IDX_UNFLVL)
      rdata_d[3:0] = underflow_irq_level_q;
    else if (idx == `SDBT_IDX_CMPLVL)
      rdata_d[7:0] = compare_irq_level_q;
    else if (idx == `SDBT_IDX_CMD)
      rdata_d[1:0] = command_target_q;
    else if (idx == `SDBT_IDX_FLAGS)
      rdata_d[7:0] = irq_flag_bits_q;
    else if (idx == `SDBT_IDX_LOW_COUNTER)
      rdata_d[7:0] = low_counter;
    else if (idx == `SDBT_IDX_HIGH_COUNTER)
      rdata_d[7:0] = high_counter;
    else if (idx == `SDBT_IDX_LOW_PERIOD)
      rdata_d[7:0] = low_period_q;
    else if (idx == `SDBT_IDX_HIGH_PERIOD)
      rdata_d[7:0] = high_period_q;
    else if (in_cmp && !cmp_hi)
      rdata_d[7:0] = low_compare_q[8*cmp_ch +: 8];
    else if (in_cmp && cmp_hi)
      rdata_d[7:0] = high_compare_q[8*cmp_ch +: 8];
    else
      err_d = 1'b1;
  end

  always @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      PRDATA_O  <= `SDBT_ZERO32;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O  <= setup;
      PSLVERR_O <= setup && err_d;
      if (setup && !PWRITE_I)
        PRDATA_O <= rdata_d;
    end
  end

endmodule // sdbt_top

`default_nettype wire

// ===== sdbt_asserts.sv
// Checker for sdbt_top: APB answer timing, request levels and forced outputs.
// Assumes it is bound to sdbt_top and that APB requests are held until ready.
`timescale 1ns/1ps
`default_nettype none
`include "sdbt_defines.vh"

// ============================================================
// Shadow state and properties
module sdbt_asserts
(
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic [11:0] IRQ_LEVEL_O,
  input wire logic [5:0]  EVENT_O,
  input wire logic [7:0]  WAVEFORM_O
);
  wire  [5:0] ix = PADDR_I[7:2];
  wire        wr = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O;
  wire        mapped = ix inside {6'h00, 6'h02, 6'h04, 6'h06, 6'h07, 6'h08, 6'h0C,
                                  [6'h20:6'h21], [6'h26:6'h2F]};
  logic [3:0] clk_sel_q;
  logic [3:0] unf_lvl_q;
  logic [7:0] cmp_lvl_q;
  logic [7:0] force_q;

  // A hard reset wipes force bits too, so the shadow follows it to avoid false alarms.
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      clk_sel_q <= 4'h0;
      unf_lvl_q <= 4'h0;
      cmp_lvl_q <= 8'h00;
      force_q   <= 8'h00;
    end
    else if (wr)
    begin
      case (ix)
        `SDBT_IDX_CLKSRC: clk_sel_q <= PWDATA_I[3:0];
        `SDBT_IDX_UNFLVL: unf_lvl_q <= PWDATA_I[3:0];
        `SDBT_IDX_CMPLVL: cmp_lvl_q <= PWDATA_I[7:0];
        `SDBT_IDX_FORCE:  force_q <= PWDATA_I[7:0];
        `SDBT_IDX_CMD:
          if (PWDATA_I[3:2] == 2'h3 && clk_sel_q == 4'h0)
            force_q <= force_q & ~{{4{PWDATA_I[1]}}, {4{PWDATA_I[0]}}};
        default: ;
      endcase
    end
  end

  default clocking dc @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  property p_ready_after_setup;
    PSEL_I && !PENABLE_I |=> PREADY_O;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  property p_ready_pulse;
    PREADY_O |=> !PREADY_O;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_err_map;
    PREADY_O |-> PSLVERR_O == !mapped;
  endproperty
  a_err_map: assert property (p_err_map) else $error("error flag wrong");
  property p_cmd_zero;
    PREADY_O && !PWRITE_I && ix == `SDBT_IDX_CMD |-> PRDATA_O[31:2] == 30'h0;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command read not zero");
  property p_lunf_req;
    EVENT_O[0] |=> IRQ_LEVEL_O[1:0] == $past(unf_lvl_q[1:0]);
  endproperty
  a_lunf_req: assert property (p_lunf_req) else $error("low underflow level wrong");
  property p_hunf_req;
    EVENT_O[1] |=> IRQ_LEVEL_O[3:2] == $past(unf_lvl_q[3:2]);
  endproperty
  a_hunf_req: assert property (p_hunf_req) else $error("high underflow level");
  property p_cmp_req;
    EVENT_O[5] |=> IRQ_LEVEL_O[11:10] == $past(cmp_lvl_q[7:6]);
  endproperty
  a_cmp_req: assert property (p_cmp_req) else $error("compare level wrong");
  // Force takes priority over any tick in sdbt_half, so the three stopped cycles are margin only.
  property p_force_stopped;
    $past(clk_sel_q, 3) == 4'h0 && $past(clk_sel_q, 2) == 4'h0 && $past(clk_sel_q) == 4'h0
      |-> WAVEFORM_O == $past(force_q);
  endproperty
  a_force_stopped: assert property (p_force_stopped) else $error("forced output lost");

  c_lunf: cover property (EVENT_O[0]);
  c_err: cover property (PSLVERR_O);
  c_cmpd: cover property (EVENT_O[5]);
endmodule // sdbt_asserts

bind sdbt_top sdbt_asserts u_chk (.CLK_I, .RESET_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .IRQ_LEVEL_O, .EVENT_O, .WAVEFORM_O);
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for sdbt_top: registers, split counting, flags and commands.
// Assumes the checker is bound on its own; event channels pulse in one scenario only.
`timescale 1ns/1ps
`default_nettype none
`include "sdbt_defines.vh"

// ============================================================
// Bench
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [5:0]  ack = 6'h00;
  logic [7:0]  evch = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] lvl;
  logic [5:0]  evt;
  logic [7:0]  wave;
  logic [31:0] rd;
  logic        err;
  int          n;
  int          errors = 0;
  int          tests_run = 0;

  always #2 clk = ~clk;

  sdbt_top dut
  (
    .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .EVENT_CH_I(evch), .IRQ_ACK_I(ack), .IRQ_LEVEL_O(lvl),
    .EVENT_O(evt), .WAVEFORM_O(wave)
  );

  task automatic final_report();
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits for ready (k < 0) or an event bit; a bound that runs out ends the run.
  task automatic wait_for(input int k, input int lim);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while ((k < 0 ? pready : evt[k]) !== 1'b1 && n < lim);
    if ((k < 0 ? pready : evt[k]) !== 1'b1)
    begin
      errors++;
      final_report();
    end
  endtask

  task automatic xfer(input logic w, input logic [5:0] ix, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    wait_for(-1, 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] ix, input logic [31:0] d);
    xfer(1'b1, ix, d);
  endtask

  task automatic rdc(input logic [5:0] ix, input logic [31:0] exp);
    xfer(1'b0, ix, 32'h0);
    chk(rd, exp);
  endtask

  task automatic t_reset();
    wr(6'h01, 32'hFF);
    for (int i = 0; i < 64; i++)
    begin
      rdc(i[5:0], 32'h0);
      chk({31'h0, err}, {31'h0, !(i inside {0, 2, 4, 6, 7, 8, 12, [32:33], [38:47]})});
    end
  endtask

  task automatic t_rw();
    wr(`SDBT_IDX_CMD, 32'h0B);
    rdc(`SDBT_IDX_CMD, 32'h03);
    wr(`SDBT_IDX_UNFLVL, 32'h0B);
    rdc(`SDBT_IDX_UNFLVL, 32'h0B);
    wr(`SDBT_IDX_CMPLVL, 32'hE4);
    rdc(`SDBT_IDX_CMPLVL, 32'hE4);
    wr(`SDBT_IDX_CMP_LAST, 32'h77);
    rdc(`SDBT_IDX_CMP_LAST, 32'h77);
    for (int i = 0; i < 2; i++)
    begin
      wr(`SDBT_IDX_FORCE, i ? 32'hA5 : 32'h5A);
      repeat (3) @(posedge clk);
      chk({24'h0, wave}, i ? 32'hA5 : 32'h5A);
    end
  endtask

  // Each source is acknowledged after its first event so the second one is a fresh set.
  task automatic t_split();
    wr(`SDBT_IDX_UPPER_ZEROED_SETTING, 32'h2);
    wr(`SDBT_IDX_LOW_PERIOD, 32'h05);
    wr(`SDBT_IDX_HIGH_PERIOD, 32'h02);
    rdc(`SDBT_IDX_LOW_PERIOD, 32'h05);
    rdc(`SDBT_IDX_HIGH_PERIOD, 32'h02);
    wr(`SDBT_IDX_CMP_BASE, 32'h03);
    wr(`SDBT_IDX_CLKSRC, 32'h1);
    for (int k = 0; k < 6; k++)
    begin
      wait_for(k, 2000);
      ack[k] <= 1'b1;
      @(posedge clk);
      ack <= 6'h00;
      wait_for(k, 2000);
      chk(n + 1, k == 1 ? 3 : 6);
    end
    wr(`SDBT_IDX_CLKSRC, 32'h0);
    repeat (4) @(posedge clk);
    rdc(`SDBT_IDX_FLAGS, 32'hF3);
    chk({20'h0, lvl}, 32'hE4B);
    wr(`SDBT_IDX_FLAGS, 32'h11);
    wr(`SDBT_IDX_FLAGS, 32'h00);
    rdc(`SDBT_IDX_FLAGS, 32'hE2);
    ack <= 6'h02;
    @(posedge clk);
    ack <= 6'h00;
    repeat (2) @(posedge clk);
    rdc(`SDBT_IDX_FLAGS, 32'hE0);
    chk({20'h0, lvl}, 32'hE40);
  endtask

  task automatic t_modes();
    for (int m = 1; m >= 0; m--)
    begin
      wr(`SDBT_IDX_UPPER_ZEROED_SETTING, m);
      wr(`SDBT_IDX_HIGH_COUNTER, 32'h55);
      wr(`SDBT_IDX_LOW_COUNTER, 32'h80);
      wr(`SDBT_IDX_CLKSRC, 32'h1);
      repeat (6) @(posedge clk);
      wr(`SDBT_IDX_CLKSRC, 32'h0);
      rdc(`SDBT_IDX_HIGH_COUNTER, m ? 32'h00 : 32'h55);
    end
  endtask

  task automatic t_cmd();
    wr(`SDBT_IDX_UPPER_ZEROED_SETTING, 32'h2);
    wr(`SDBT_IDX_LOW_PERIOD, 32'h33);
    wr(`SDBT_IDX_HIGH_PERIOD, 32'h44);
    wr(`SDBT_IDX_CMD, 32'h0D);
    rdc(`SDBT_IDX_LOW_PERIOD, 32'h00);
    wr(`SDBT_IDX_CMD, 32'h0C);
    wr(`SDBT_IDX_CMD, 32'h07);
    wr(`SDBT_IDX_CLKSRC, 32'h1);
    wr(`SDBT_IDX_CMD, 32'h0E);
    rdc(`SDBT_IDX_HIGH_PERIOD, 32'h44);
    wr(`SDBT_IDX_LOW_PERIOD, 32'h40);
    wr(`SDBT_IDX_LOW_COUNTER, 32'h10);
    wr(`SDBT_IDX_CMD, 32'h09);
    xfer(1'b0, `SDBT_IDX_LOW_COUNTER, 32'h0);
    chk({31'h0, rd[7:0] >= 8'h38}, 32'h1);
    wr(`SDBT_IDX_LOW_COUNTER, 32'h90);
    xfer(1'b0, `SDBT_IDX_LOW_COUNTER, 32'h0);
    chk({31'h0, rd[7:0] inside {[8'h88:8'h90]}}, 32'h1);
    wr(`SDBT_IDX_CLKSRC, 32'h0);
  endtask

  // Channel 1 counts; channel 0 pulses alongside and must be ignored.
  task automatic t_event();
    wr(`SDBT_IDX_LOW_COUNTER, 32'h20);
    wr(`SDBT_IDX_CLKSRC, 32'h9);
    for (int i = 0; i < 3; i++)
    begin
      evch <= 8'h03;
      @(posedge clk);
      evch <= 8'h00;
      @(posedge clk);
    end
    wr(`SDBT_IDX_CLKSRC, 32'h0);
    rdc(`SDBT_IDX_LOW_COUNTER, 32'h1D);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rw();
    t_split();
    t_modes();
    t_cmd();
    t_event();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
